// *** inc/motor_fault_cfg_pkg.sv ***
package motor_fault_cfg_pkg;

  // ****************************************
  // register offsets and reset values
  // ****************************************
  localparam logic [7:0]  off_lock_reaction = 8'h92;
  localparam logic [7:0]  off_lock_supply   = 8'h94;
  localparam logic [7:0]  off_mon_source    = 8'hA4;
  localparam logic [7:0]  off_pin_sleep     = 8'hA6;
  localparam logic [7:0]  off_device        = 8'hA8;
  localparam logic [31:0] rst_lock_reaction = 32'h0000_0000;
  localparam logic [31:0] rst_lock_supply   = 32'h0000_0000;
  localparam logic [31:0] rst_mon_source    = 32'h0000_0000;
  localparam logic [31:0] rst_pin_sleep     = 32'h0000_0000;
  localparam logic [31:0] rst_device        = 32'h0000_0000;

  // ****************************************
  // timing
  // ****************************************
  localparam int clk_hz       = 20_000_000;
  localparam int us_per_s     = 1_000_000;
  localparam int cyc_per_us   = clk_hz / us_per_s;
  localparam int us_per_ms    = 1000;

  // ****************************************
  // register layouts
  // ****************************************
  typedef struct packed {
    logic       parity;
    logic       rsvd30;
    logic [2:0] no_motor_deglitch;
    logic [3:0] cycle_limit_mode;
    logic [3:0] lock_current_limit;
    logic [3:0] lock_current_mode;
    logic [3:0] lock_current_deglitch;
    logic [2:0] cycle_limit_retry;
    logic       rsvd7;
    logic [3:0] motor_lock_reaction;
    logic [2:0] lock_retry_time_sel;
  } lock_reaction_t;

  typedef struct packed {
    logic       parity;
    logic       abnormal_speed_detect_en;
    logic       sync_loss_detect_en;
    logic       missing_motor_detect_en;
    logic [3:0] overspeed_lock_threshold;
    logic [2:0] sync_loss_count;
    logic [2:0] missing_motor_current_thr;
    logic       overvoltage_recovery_mode;
    logic [2:0] supply_upper_limit;
    logic       undervoltage_recovery_mode;
    logic [2:0] supply_lower_limit;
    logic [2:0] auto_retry_count;
    logic [2:0] min_speed_sel;
    logic [1:0] speed_jump_ratio;
    logic [1:0] zero_command_duty_thr;
  } lock_supply_t;

  typedef struct packed {
    logic        parity;
    logic [11:0] monitor_a_var_addr;
    logic [11:0] monitor_b_var_addr;
    logic [1:0]  brake_source;
    logic [1:0]  direction_source;
    logic [1:0]  speed_command_source;
    logic        rsvd0;
  } mon_source_t;

  typedef struct packed {
    logic        parity;
    logic [1:0]  pin36_function_sel;
    logic        rsvd28;
    logic        pin37_38_function_sel;
    logic [6:0]  rsvd26;
    logic [1:0]  sleep_time_sel;
    logic [17:0] watchdog_bits;
  } pin_sleep_t;

  // ****************************************
  // modes and states
  // ****************************************
  typedef enum logic [2:0] {
    drive_normal  = 3'h0,
    drive_tristate = 3'h1,
    drive_recirc  = 3'h2,
    drive_hs_on   = 3'h3,
    drive_ls_on   = 3'h4
  } drive_t;

  typedef enum logic [2:0] {
    lk_run     = 3'b001,
    lk_latched = 3'b010,
    lk_retry   = 3'b100
  } lock_state_t;

  localparam logic [3:0] react_report = 4'h8;
  localparam logic [3:0] react_auto   = 4'h4;

  // detector events into the block
  typedef struct packed {
    logic abnormal_speed;
    logic sync_lost;
    logic missing_motor;
    logic low_speed;
  } lock_events_t;

endpackage

// *** src/motor_fault_config_regs.sv ***
// Notes on behaviour
// - reaction 0h-3h: lock latches, fault pin low, tristate/recirc/HS on/LS on.
// - reaction 4h-7h: same drive states, automatic recovery after retry interval.
// - reaction 8h reports only; 9h and above ignore lock detection.
// - retry time codes select 100 to 10000 ms.
// - bits 30, 29, 28 enable abnormal-speed, sync-loss, missing-motor detectors.
// - overspeed threshold is (n+1) times 250 Hz.
// - sync-loss lock trips after n+2 losses.
// - missing-motor threshold voltage 5 mV to 40 mV, divided by sense gain.
// - bit 17: overvoltage latches at zero, clears itself when one.
// - upper supply limit: none, then 20 to 60 V.
// - bit 13: undervoltage latches at zero, clears itself when one.
// - lower supply limit: none, then 6 to 15 V.
// - retry count: unlimited, then 2 to 20 attempts.
// - lock fault when speed below 0.5 to 25 Hz.
// - abnormal speed when speed ratio exceeds 2, 4, 6 or 8.
// - target speed zero below 1 to 2.5 percent duty.
// - two 12-bit monitor variable addresses at bits 30-19 and 18-7.
// - brake source: pin, forced on, forced off.
// - direction source: pin, or forced clockwise A-B-C.
// - speed command source: analog, pulse duty, serial, frequency.
// - pin 36 selects monitor B or phase sense; bit routes monitors to 37/38.
// - sleep only after speed input low for 50 us to 200 ms.
// - sense gain 0.15, 0.3, 0.6 or 1.2 V/A.
`timescale 1ns/1ps
`default_nettype none

module motor_fault_config_regs
  import motor_fault_cfg_pkg::*;
#(
  parameter int tick_cycles = cyc_per_us
)(
  input  wire logic         clock,
  input  wire logic         rstn,
  input  wire logic [7:0]   reg_addr,
  input  wire logic [31:0]  reg_wdata,
  input  wire logic         reg_write,
  input  wire logic         reg_read,
  output var  logic [31:0]  reg_rdata,
  input  wire lock_events_t lock_events,
  input  wire logic         clear_faults,
  input  wire logic         overvoltage_seen,
  input  wire logic         undervoltage_seen,
  input  wire logic [9:0]   duty_permille,
  input  wire logic         brake_pin,
  input  wire logic         direction_pin,
  input  wire logic         speed_input_low,
  input  wire logic [1:0]   sense_amp_gain,
  output var  logic         fault_indicator_pin_n,
  output var  drive_t       drive_override,
  output var  logic         lock_fault,
  output var  logic         lock_report,
  output var  logic         overvoltage_fault,
  output var  logic         undervoltage_fault,
  output var  logic [5:0]   upper_limit_volts,
  output var  logic [5:0]   lower_limit_volts,
  output var  logic [12:0]  overspeed_thr_hz,
  output var  logic [3:0]   speed_jump_limit,
  output var  logic [5:0]   min_speed_half_hz,
  output var  logic [15:0]  missing_motor_thr_uv,
  output var  logic [10:0]  sense_gain_mv_per_a,
  output var  logic         target_speed_zero,
  output var  logic         brake_active,
  output var  logic         direction_eff,
  output var  logic [1:0]   speed_command_source,
  output var  logic [11:0]  monitor_a_var_addr,
  output var  logic [11:0]  monitor_b_var_addr,
  output var  logic [1:0]   pin36_function_sel,
  output var  logic         pin37_38_function_sel,
  output var  logic         sleep_request
);

  // ****************************************
  // lookup functions
  // ****************************************
  function automatic logic [13:0] retry_ms(input logic [2:0] c);
    case (c)
      3'h0:    retry_ms = 14'd100;
      3'h1:    retry_ms = 14'd500;
      3'h2:    retry_ms = 14'd1000;
      3'h3:    retry_ms = 14'd2000;
      3'h4:    retry_ms = 14'd3000;
      3'h5:    retry_ms = 14'd5000;
      3'h6:    retry_ms = 14'd7500;
      default: retry_ms = 14'd10000;
    endcase
  endfunction

  function automatic logic [5:0] upper_v(input logic [2:0] c);
    case (c)
      3'h0:    upper_v = 6'd0;
      3'h1:    upper_v = 6'd20;
      3'h2:    upper_v = 6'd25;
      3'h3:    upper_v = 6'd30;
      3'h4:    upper_v = 6'd35;
      3'h5:    upper_v = 6'd40;
      3'h6:    upper_v = 6'd50;
      default: upper_v = 6'd60;
    endcase
  endfunction

  function automatic logic [5:0] lower_v(input logic [2:0] c);
    case (c)
      3'h0:    lower_v = 6'd0;
      3'h1:    lower_v = 6'd6;
      3'h2:    lower_v = 6'd7;
      3'h3:    lower_v = 6'd8;
      3'h4:    lower_v = 6'd9;
      3'h5:    lower_v = 6'd10;
      3'h6:    lower_v = 6'd12;
      default: lower_v = 6'd15;
    endcase
  endfunction

  function automatic logic [4:0] retry_cap(input logic [2:0] c);
    case (c)
      3'h0:    retry_cap = 5'd0;
      3'h1:    retry_cap = 5'd2;
      3'h2:    retry_cap = 5'd3;
      3'h3:    retry_cap = 5'd5;
      3'h4:    retry_cap = 5'd7;
      3'h5:    retry_cap = 5'd10;
      3'h6:    retry_cap = 5'd15;
      default: retry_cap = 5'd20;
    endcase
  endfunction

  function automatic logic [5:0] min_speed(input logic [2:0] c);
    case (c)
      3'h0:    min_speed = 6'd1;
      3'h1:    min_speed = 6'd2;
      3'h2:    min_speed = 6'd4;
      3'h3:    min_speed = 6'd6;
      3'h4:    min_speed = 6'd10;
      3'h5:    min_speed = 6'd20;
      3'h6:    min_speed = 6'd30;
      default: min_speed = 6'd50;
    endcase
  endfunction

  function automatic logic [15:0] no_motor_uv(input logic [2:0] c);
    case (c)
      3'h0:    no_motor_uv = 16'd5000;
      3'h1:    no_motor_uv = 16'd7500;
      3'h2:    no_motor_uv = 16'd10000;
      3'h3:    no_motor_uv = 16'd12500;
      3'h4:    no_motor_uv = 16'd20000;
      3'h5:    no_motor_uv = 16'd25000;
      3'h6:    no_motor_uv = 16'd30000;
      default: no_motor_uv = 16'd40000;
    endcase
  endfunction

  function automatic logic [17:0] sleep_us(input logic [1:0] c);
    case (c)
      2'h0:    sleep_us = 18'd50;
      2'h1:    sleep_us = 18'd200;
      2'h2:    sleep_us = 18'd20000;
      default: sleep_us = 18'd200000;
    endcase
  endfunction

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    lock_reaction_t lock_reaction_settings;
    lock_supply_t   lock_and_supply_fault_settings;
    mon_source_t    monitor_and_input_source_select;
    pin_sleep_t     pin_function_and_sleep_select;
    logic [31:0]    device_settings;
    logic [31:0]    rdata;
    logic [4:0]     us_div;
    logic [9:0]     ms_div;
    logic [13:0]    retry_elapsed;
    logic [4:0]     retries;
    logic [3:0]     sync_losses;
    logic [17:0]    low_us;
    lock_state_t    lk;
    drive_t         drive;
    logic           report;
    logic           ov;
    logic           uv;
    logic           fault_n;
    logic [5:0]     up_v;
    logic [5:0]     lo_v;
    logic [12:0]    abn_hz;
    logic [3:0]     jump;
    logic [5:0]     min_spd;
    logic [15:0]    nm_uv;
    logic [10:0]    gain;
    logic           zero_cmd;
    logic           brake;
    logic           dir;
    logic           sleep;
  } state_t;

  state_t st;
  state_t next_st;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic         us_tick;
    logic         ms_tick;
    logic         sync_trip;
    logic         lock_hit;
    logic [3:0]   react;
    logic [9:0]   zero_thr;
    lock_supply_t f2;
    mon_source_t  p1;
    next_st = st;
    f2 = st.lock_and_supply_fault_settings;
    p1 = st.monitor_and_input_source_select;
    react = st.lock_reaction_settings.motor_lock_reaction;
    next_st.report = 1'b0;

    // register writes, one word at a printed offset
    if (reg_write) begin
      case (reg_addr)
        off_lock_reaction: next_st.lock_reaction_settings = reg_wdata;
        off_lock_supply:   next_st.lock_and_supply_fault_settings = reg_wdata;
        off_mon_source:    next_st.monitor_and_input_source_select = reg_wdata;
        off_pin_sleep:     next_st.pin_function_and_sleep_select = reg_wdata;
        off_device:        next_st.device_settings = reg_wdata;
        default:           next_st.device_settings = st.device_settings;
      endcase
    end
    // register reads, unmapped reads give zero
    if (reg_read) begin
      case (reg_addr)
        off_lock_reaction: next_st.rdata = st.lock_reaction_settings;
        off_lock_supply:   next_st.rdata = st.lock_and_supply_fault_settings;
        off_mon_source:    next_st.rdata = st.monitor_and_input_source_select;
        off_pin_sleep:     next_st.rdata = st.pin_function_and_sleep_select;
        off_device:        next_st.rdata = st.device_settings;
        default:           next_st.rdata = 32'h0000_0000;
      endcase
    end

    // microsecond and millisecond enables
    us_tick = (st.us_div == 5'(tick_cycles - 1));
    next_st.us_div = us_tick ? 5'h00 : st.us_div + 5'h01;
    ms_tick = us_tick && (st.ms_div == 10'(us_per_ms - 1));
    if (us_tick) begin
      next_st.ms_div = ms_tick ? 10'h000 : st.ms_div + 10'h001;
    end

    // sync loss counting, trips at n+2 losses
    sync_trip = 1'b0;
    if (lock_events.sync_lost && f2.sync_loss_detect_en) begin
      if (st.sync_losses + 4'h1 >= {1'b0, f2.sync_loss_count} + 4'h2) begin
        sync_trip = 1'b1;
        next_st.sync_losses = 4'h0;
      end else begin
        next_st.sync_losses = st.sync_losses + 4'h1;
      end
    end

    // abnormal-speed, sync-loss and missing-motor detectors gated by their enables, low speed ungated
    lock_hit = (lock_events.abnormal_speed && f2.abnormal_speed_detect_en)
             || sync_trip
             || (lock_events.missing_motor && f2.missing_motor_detect_en)
             || lock_events.low_speed;

    // lock reaction sequence
    case (st.lk)
      lk_run: begin
        if (lock_hit && react < react_auto) begin
          next_st.lk = lk_latched;
          next_st.drive = drive_t'(react[2:0] + 3'h1);
        end else if (lock_hit && react < react_report) begin
          next_st.drive = drive_t'({1'b0, react[1:0]} + 3'h1);
          next_st.retry_elapsed = 14'h0000;
          if (retry_cap(f2.auto_retry_count) != 5'd0
              && st.retries >= retry_cap(f2.auto_retry_count)) begin
            next_st.lk = lk_latched;
          end else begin
            next_st.lk = lk_retry;
            next_st.retries = st.retries + 5'd1;
          end
        end else if (lock_hit && react == react_report) begin
          next_st.report = 1'b1;
        end
      end
      lk_retry: begin
        if (ms_tick) begin
          next_st.retry_elapsed = st.retry_elapsed + 14'h0001;
        end
        if (st.retry_elapsed >= retry_ms(st.lock_reaction_settings.lock_retry_time_sel))
        begin
          next_st.lk = lk_run;
          next_st.drive = drive_normal;
        end
      end
      lk_latched: begin
        // a new lock in the clearing cycle keeps the fault
        if (clear_faults && !lock_hit) begin
          next_st.lk = lk_run;
          next_st.drive = drive_normal;
          next_st.retries = 5'd0;
        end
      end
      default: begin
        next_st.lk = lk_run;
        next_st.drive = drive_normal;
      end
    endcase

    // supply window faults, set wins over clear
    if (overvoltage_seen) begin
      next_st.ov = 1'b1;
    end else if (f2.overvoltage_recovery_mode || clear_faults) begin
      next_st.ov = 1'b0;
    end
    if (undervoltage_seen) begin
      next_st.uv = 1'b1;
    end else if (f2.undervoltage_recovery_mode || clear_faults) begin
      next_st.uv = 1'b0;
    end
    next_st.fault_n = !(next_st.lk == lk_latched || next_st.ov || next_st.uv);

    // decoded settings
    next_st.up_v = upper_v(f2.supply_upper_limit);
    next_st.lo_v = lower_v(f2.supply_lower_limit);
    next_st.abn_hz = 13'({f2.overspeed_lock_threshold} + 5'd1) * 13'd250;
    next_st.jump = {f2.speed_jump_ratio, 1'b0} + 4'h2;
    next_st.min_spd = min_speed(f2.min_speed_sel);
    next_st.nm_uv = no_motor_uv(f2.missing_motor_current_thr);
    next_st.gain = 11'd150 << sense_amp_gain;

    // zero command below the duty threshold, in tenths of a percent
    zero_thr = 10'd10 + 10'd5 * 10'(f2.zero_command_duty_thr);
    next_st.zero_cmd = duty_permille < zero_thr;

    // brake and direction sources
    case (p1.brake_source)
      2'h1:    next_st.brake = 1'b1;
      2'h2:    next_st.brake = 1'b0;
      default: next_st.brake = brake_pin;
    endcase
    next_st.dir = (p1.direction_source == 2'h1) ? 1'b0 : direction_pin;

    // sleep entry after the input holds low long enough
    if (!speed_input_low) begin
      next_st.low_us = 18'h00000;
      next_st.sleep = 1'b0;
    end else if (st.low_us >= sleep_us(st.pin_function_and_sleep_select.sleep_time_sel))
    begin
      next_st.sleep = 1'b1;
    end else if (us_tick) begin
      next_st.low_us = st.low_us + 18'h00001;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
      st.lock_reaction_settings <= rst_lock_reaction;
      st.lock_and_supply_fault_settings <= rst_lock_supply;
      st.monitor_and_input_source_select <= rst_mon_source;
      st.pin_function_and_sleep_select <= rst_pin_sleep;
      st.device_settings <= rst_device;
      st.lk <= lk_run;
      st.drive <= drive_normal;
      st.fault_n <= 1'b1;
      st.jump <= 4'h2;
      st.min_spd <= 6'd1;
      st.nm_uv <= 16'd5000;
      st.gain <= 11'd150;
      st.abn_hz <= 13'd250;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign reg_rdata             = st.rdata;
  assign fault_indicator_pin_n = st.fault_n;
  assign drive_override        = st.drive;
  assign lock_fault            = (st.lk == lk_latched);
  assign lock_report           = st.report;
  assign overvoltage_fault     = st.ov;
  assign undervoltage_fault    = st.uv;
  assign upper_limit_volts     = st.up_v;
  assign lower_limit_volts     = st.lo_v;
  assign overspeed_thr_hz      = st.abn_hz;
  assign speed_jump_limit      = st.jump;
  assign min_speed_half_hz     = st.min_spd;
  assign missing_motor_thr_uv  = st.nm_uv;
  assign sense_gain_mv_per_a   = st.gain;
  assign target_speed_zero     = st.zero_cmd;
  assign brake_active          = st.brake;
  assign direction_eff         = st.dir;
  // source and monitor fields drive straight from their stored bits
  assign speed_command_source  = st.monitor_and_input_source_select.speed_command_source;
  assign monitor_a_var_addr    = st.monitor_and_input_source_select.monitor_a_var_addr;
  assign monitor_b_var_addr    = st.monitor_and_input_source_select.monitor_b_var_addr;
  assign pin36_function_sel    = st.pin_function_and_sleep_select.pin36_function_sel;
  assign pin37_38_function_sel = st.pin_function_and_sleep_select.pin37_38_function_sel;
  assign sleep_request         = st.sleep;

endmodule

`default_nettype wire

// *** verif/motor_fault_config_regs_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module motor_fault_config_regs_assertions
  import motor_fault_cfg_pkg::*;
(
  input wire logic         clock,
  input wire logic         rstn,
  input wire logic         reg_read,
  input wire logic [31:0]  reg_rdata,
  input wire lock_events_t lock_events,
  input wire logic         clear_faults,
  input wire logic         overvoltage_seen,
  input wire logic         undervoltage_seen,
  input wire logic         speed_input_low,
  input wire logic [1:0]   sense_amp_gain,
  input wire logic         fault_indicator_pin_n,
  input wire drive_t       drive_override,
  input wire logic         lock_fault,
  input wire logic         lock_report,
  input wire logic         overvoltage_fault,
  input wire logic         undervoltage_fault,
  input wire logic [10:0]  sense_gain_mv_per_a,
  input wire logic         sleep_request
);
  // ****************************************
  // port relations
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  chk_gain_decode: assert property (
    sense_gain_mv_per_a == (11'd150 << $past(sense_amp_gain)))
    else $error("sense gain decode wrong");
  chk_report_pulse: assert property (
    lock_report |=> !lock_report) else $error("report longer than one cycle");
  chk_ov_set: assert property (
    overvoltage_seen |=> overvoltage_fault) else $error("overvoltage not flagged");
  chk_uv_set: assert property (
    undervoltage_seen |=> undervoltage_fault) else $error("undervoltage not flagged");
  chk_lock_drive: assert property (
    lock_fault |-> drive_override != drive_normal) else $error("lock without drive state");
  chk_lock_pin: assert property (
    lock_fault |-> !fault_indicator_pin_n) else $error("lock without fault pin");
  chk_lock_clear: assert property (
    lock_fault && !fault_indicator_pin_n && clear_faults && lock_events == '0
    |=> !lock_fault) else $error("lock not cleared");
  chk_sleep_drop: assert property (
    !speed_input_low |=> !sleep_request) else $error("sleep with speed input high");
  chk_rdata_hold: assert property (
    !reg_read |=> $stable(reg_rdata)) else $error("read data moved without read");
endmodule

bind motor_fault_config_regs motor_fault_config_regs_assertions i_chk (.*);
`default_nettype wire

// *** verif/motor_fault_config_regs_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module motor_fault_config_regs_bench
  import motor_fault_cfg_pkg::*;
;
  logic clock = 0, rstn = 0, reg_write = 0, reg_read = 0, clear_faults = 0;
  logic overvoltage_seen = 0, undervoltage_seen = 0, brake_pin = 0, direction_pin = 0;
  logic speed_input_low = 0, fault_indicator_pin_n, lock_fault, lock_report;
  logic overvoltage_fault, undervoltage_fault, target_speed_zero, brake_active;
  logic direction_eff, pin37_38_function_sel, sleep_request;
  logic [7:0]   reg_addr = 0;
  logic [31:0]  reg_wdata = 0, reg_rdata, d;
  logic [9:0]   duty_permille = 0;
  logic [1:0]   sense_amp_gain = 0, speed_command_source, pin36_function_sel;
  lock_events_t lock_events = '0;
  drive_t       drive_override;
  logic [5:0]   upper_limit_volts, lower_limit_volts, min_speed_half_hz;
  logic [12:0]  overspeed_thr_hz;
  logic [3:0]   speed_jump_limit, n;
  logic [15:0]  missing_motor_thr_uv;
  logic [10:0]  sense_gain_mv_per_a;
  logic [11:0]  monitor_a_var_addr, monitor_b_var_addr;
  int error_cnt = 0, comparisons = 0, cycles = 0, reps = 0;
  int upv[8] = '{0, 20, 25, 30, 35, 40, 50, 60};
  int lov[8] = '{0, 6, 7, 8, 9, 10, 12, 15};
  int msv[8] = '{1, 2, 4, 6, 10, 20, 30, 50};
  int nmv[8] = '{5000, 7500, 10000, 12500, 20000, 25000, 30000, 40000};
  int zdv[4] = '{10, 15, 20, 25};
  logic [7:0] offs[5] = '{off_lock_reaction, off_lock_supply, off_mon_source,
                          off_pin_sleep, off_device};

  motor_fault_config_regs #(.tick_cycles(1)) i_dut (.*);

  // ****************************************
  // clock, watchdog and bus tasks
  // ****************************************
  always #25 clock = ~clock;

  // cycle ceiling and report pulse counter
  always @(negedge clock) begin
    cycles++;
    if (lock_report === 1'b1) reps++;
    if (cycles == 8000) begin
      error_cnt++;
      finish_test();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic w2;
    repeat (2) @(negedge clock);
  endtask

  // write, then let decoded outputs settle
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = v;
    reg_write = 1;
    @(negedge clock);
    reg_write = 0;
    w2();
  endtask

  task automatic rd(input logic [7:0] a);
    @(negedge clock);
    reg_addr = a;
    reg_read = 1;
    @(negedge clock);
    reg_read = 0;
    d = reg_rdata;
  endtask

  task automatic ev(input lock_events_t e);
    lock_events = e;
    @(negedge clock);
    lock_events = '0;
    w2();
  endtask

  task automatic clr;
    clear_faults = 1;
    @(negedge clock);
    clear_faults = 0;
    w2();
  endtask

  task automatic lk(input logic f, input drive_t dv, input logic p);
    chk("lock", lock_fault, f);
    chk("drive", drive_override, dv);
    chk("pin", fault_indicator_pin_n, p);
  endtask

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    repeat (4) @(negedge clock);
    rstn = 1;
    foreach (offs[i]) begin
      rd(offs[i]);
      chk("reset", d, 32'h0);
      wr(offs[i], 32'h5A5A_5A50 + i);
      rd(offs[i]);
      chk("readback", d, 32'h5A5A_5A50 + i);
    end
    wr(8'h96, 32'hFFFF_FFFF);
    rd(8'h96);
    chk("unmapped", d, 32'h0);
    $display("test registers done");
    // every code of the threshold fields
    for (int i = 0; i < 16; i++) begin
      n = i;
      sense_amp_gain = n[1:0];
      wr(off_lock_supply, {4'h0, n, 3'h0, n[2:0], 1'b0, n[2:0], 1'b0, n[2:0], 3'h0, n[2:0],
                           n[1:0], n[1:0]});
      chk("overspeed", overspeed_thr_hz, (i + 1) * 250);
      chk("nomotor", missing_motor_thr_uv, nmv[i % 8]);
      chk("upper", upper_limit_volts, upv[i % 8]);
      chk("lower", lower_limit_volts, lov[i % 8]);
      chk("minspeed", min_speed_half_hz, msv[i % 8]);
      chk("jump", speed_jump_limit, 2 * (i % 4) + 2);
      chk("gain", sense_gain_mv_per_a, 150 << (i % 4));
      duty_permille = 10'(zdv[i % 4] - 1);
      w2();
      chk("zeroduty", target_speed_zero, 1'b1);
      duty_permille = 10'(zdv[i % 4]);
      w2();
      chk("zeroduty", target_speed_zero, 1'b0);
    end
    sense_amp_gain = 0;
    $display("test thresholds done");
    // input sources and monitor pin selects, both pin levels
    for (int k = 0; k < 8; k++) begin
      n = k;
      brake_pin = n[2];
      direction_pin = n[2];
      wr(off_mon_source, {1'b0, 12'hABC, 12'h5A3, n[1:0], n[1:0], n[1:0], 1'b0});
      chk("mona", monitor_a_var_addr, 12'hABC);
      chk("monb", monitor_b_var_addr, 12'h5A3);
      chk("speedsrc", speed_command_source, n[1:0]);
      if (n[1:0] < 3) chk("brake", brake_active, n[1:0] == 0 ? n[2] : n[1:0] == 1);
      if (n[1:0] < 2) chk("dir", direction_eff, n[1:0] == 0 ? n[2] : 1'b0);
      wr(off_pin_sleep, {1'b0, n[1:0], 1'b0, n[0], 27'h0});
      chk("pin36", pin36_function_sel, n[1:0]);
      chk("pin3738", pin37_38_function_sel, n[0]);
    end
    $display("test routing done");
    // sleep check time, one cycle per microsecond
    for (int c = 0; c < 2; c++) begin
      n = c;
      wr(off_pin_sleep, {12'h0, n[1:0], 18'h0});
      speed_input_low = 1;
      repeat (c ? 196 : 46) @(negedge clock);
      chk("sleep", sleep_request, 1'b0);
      repeat (8) @(negedge clock);
      chk("sleep", sleep_request, 1'b1);
      speed_input_low = 0;
      w2();
      chk("sleep", sleep_request, 1'b0);
    end
    $display("test sleep done");
    // detectors off, then each latched reaction
    wr(off_lock_reaction, 32'h0);
    wr(off_lock_supply, 32'h0);
    ev(lock_events_t'(4'b1110));
    lk(0, drive_normal, 1);
    wr(off_lock_supply, 32'h7020_0000);
    for (int c = 0; c < 4; c++) begin
      n = c;
      wr(off_lock_reaction, {25'h0, n, 3'h0});
      ev(lock_events_t'(n[0] ? 4'b1000 : 4'b0010));
      lk(1, drive_t'(c + 1), 0);
      clr();
      lk(0, drive_normal, 1);
    end
    repeat (2) ev(lock_events_t'(4'b0100));
    lk(0, drive_normal, 1);
    ev(lock_events_t'(4'b0100));
    lk(1, drive_ls_on, 0);
    clr();
    wr(off_lock_reaction, 32'h40);
    ev(lock_events_t'(4'b0001));
    chk("report", reps, 1);
    lk(0, drive_normal, 1);
    wr(off_lock_reaction, 32'h48);
    ev(lock_events_t'(4'b1111));
    chk("report", reps, 1);
    lk(0, drive_normal, 1);
    wr(off_lock_reaction, 32'h28);
    ev(lock_events_t'(4'b0001));
    chk("drive", drive_override, drive_recirc);
    chk("pin", fault_indicator_pin_n, 1'b1);
    // reset in mid-run while retrying
    rstn = 0;
    w2();
    rstn = 1;
    rd(off_lock_reaction);
    chk("reset", d, 32'h0);
    chk("drive", drive_override, drive_normal);
    $display("test lock done");
    // supply faults, latched and self-clearing
    for (int c = 0; c < 4; c++) begin
      n = c;
      wr(off_lock_supply, n[1] ? (n[0] ? 32'h2000 : 32'h2_0000) : 32'h0);
      {undervoltage_seen, overvoltage_seen} = n[0] ? 2'b10 : 2'b01;
      w2();
      chk("supply", n[0] ? undervoltage_fault : overvoltage_fault, 1'b1);
      {undervoltage_seen, overvoltage_seen} = 2'b00;
      w2();
      chk("supply", n[0] ? undervoltage_fault : overvoltage_fault, !n[1]);
      clr();
      chk("supply", n[0] ? undervoltage_fault : overvoltage_fault, 1'b0);
      chk("pin", fault_indicator_pin_n, 1'b1);
    end
    $display("test supply done");
    finish_test();
  end
endmodule
`default_nettype wire
